// *** scw_pkg.sv ***
// shared constants for the serial control word register bank
package scw_pkg;
    localparam int          WORD_BITS      = 16;
    localparam int          REG_BITS       = 11;
    localparam int          DAC_BITS       = 12;
    localparam int          DAC_CHANNELS   = 8;
    localparam int          TYPE_BIT       = 15;
    localparam int          CODE_HI        = 14;
    localparam int          CODE_LO        = 11;
    localparam int          DAC_SEL_HI     = 14;
    localparam int          DAC_SEL_LO     = 12;
    localparam logic [3:0]  NO_OPERATION         = 4'h0;
    localparam logic [3:0]  DAC_READBACK_SELECT  = 4'h1;
    localparam logic [3:0]  ADC_SEQUENCE         = 4'h2;
    localparam logic [3:0]  GENERAL_CONTROL      = 4'h3;
    localparam logic [3:0]  ADC_PIN_SELECT       = 4'h4;
    localparam logic [3:0]  DAC_PIN_SELECT       = 4'h5;
    localparam logic [3:0]  PULLDOWN_SELECT      = 4'h6;
    localparam logic [3:0]  READBACK_AND_LOAD    = 4'h7;
    localparam logic [3:0]  GPIO_OUTPUT_SELECT   = 4'h8;
    localparam logic [3:0]  GPIO_OUTPUT_LEVEL    = 4'h9;
    localparam logic [3:0]  GPIO_INPUT_SELECT    = 4'hA;
    localparam logic [3:0]  POWER_DOWN_REFERENCE = 4'hB;
    localparam logic [3:0]  OUTPUT_DRIVE_TYPE    = 4'hC;
    localparam logic [3:0]  TRISTATE_SELECT      = 4'hD;
    localparam logic [3:0]  SOFTWARE_RESET       = 4'hF;
    localparam logic [10:0] RST_DEFAULT          = 11'h000;
    localparam logic [10:0] RST_PULLDOWN         = 11'h0FF;
    localparam int          RB_EN_HI       = 4;
    localparam int          RB_EN_LO       = 3;
    localparam int          RB_CH_HI       = 2;
    localparam int          RB_CH_LO       = 0;
    localparam int          BUSY_BIT       = 8;
    localparam int          RESET_TIME_US  = 250;
    localparam int          CLK_MHZ        = 100;
    localparam int          RESET_CYCLES   = RESET_TIME_US * CLK_MHZ;
endpackage : scw_pkg

// *** scw_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module scw_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : scw_sync
`default_nettype wire

// *** scw_regbank.sv ***
// serial command word decoder and configuration register bank
//
// Summary of operation
// (RQ1) top bit 0: control code in bits 14..11
// (RQ2) top bit 1: dac write, channel bits 14..12
// (RQ3) dac write stores payload in selected channel
// (RQ4) pulldown resets 0x0FF, others reset 0x000
// (RQ5) code 0010 holds adc sequence selection
// (RQ6) codes 0100/0101 select adc and dac pins
// (RQ7) code 0111 holds load mode, readback select
// (RQ8) code 1000 gpio outputs, io7 busy option
// (RQ9) code 1001 output levels, 1010 input select
// (RQ10) code 1011 dac power-down and reference enable
// (RQ11) codes 1100 drive type, 1101 tristate
// (RQ12) readback select bits 4..3 enable readback
// (RQ13) readback select bits 2..0 pick channel
// (RQ14) host sends zeros in reserved readback bits
// (RQ15) selected data shifts out next transfer
// (RQ16) 16-bit words sampled on falling clock
// (RQ17) host waits 250 us after software reset
// (RQ18) only complete 16-bit frames are applied
// (RQ19) unlisted code 1110 is ignored
`timescale 1ns/1ps
`default_nettype none
module scw_regbank #(
    parameter int RESET_CYCLES = scw_pkg::RESET_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        sclk,
    input  wire logic        sync_n,
    input  wire logic        sdi,
    output logic             sdo,
    output logic [10:0]      adc_sequence,
    output logic [10:0]      general_control,
    output logic [10:0]      adc_pin_select,
    output logic [10:0]      dac_pin_select,
    output logic [10:0]      pulldown_select,
    output logic [10:0]      readback_and_load_mode,
    output logic [10:0]      gpio_output_select,
    output logic [10:0]      gpio_output_level,
    output logic [10:0]      gpio_input_select,
    output logic [10:0]      power_down_reference,
    output logic [10:0]      output_drive_type_select,
    output logic [10:0]      tristate_select,
    output logic [10:0]      dac_readback_select,
    output logic             busy_on_io7,
    output logic             reset_busy
);
    // ---------------- link clock domain ----------------
    logic [15:0] shift_in;
    logic [4:0]  bit_cnt;
    logic [15:0] word_link;
    logic        word_tgl;
    logic [15:0] shift_out;
    logic [15:0] next_shift;

    assign next_shift = {shift_in[14:0], sdi};

    // sample on falling sclk; a frame counts only when sixteen bits land
    always_ff @(negedge sclk or posedge sync_n) begin
        if (sync_n) begin
            bit_cnt  <= 5'h00;
            shift_in <= 16'h0000;
        end else begin
            shift_in <= next_shift; // [RQ16]
            if (bit_cnt != 5'h10) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // capture a full word and flag it by toggle; extra bits beyond 16 are ignored
    always_ff @(negedge sclk or negedge rstn) begin
        if (!rstn) begin
            word_link <= 16'h0000;
            word_tgl  <= 1'b0;
        end else if (!sync_n && bit_cnt == 5'h0F) begin
            word_link <= next_shift; // [RQ18]
            word_tgl  <= ~word_tgl;
        end
    end

    // readback word held in sys domain, stable between frames
    logic [15:0] readback_word;
    logic [15:0] rb_sync;

    // bit 15 goes out straight from the word; load the rest at the first rising edge
    always_ff @(posedge sclk or posedge sync_n) begin
        if (sync_n) begin
            shift_out <= 16'h0000;
        end else if (bit_cnt == 5'h01) begin
            shift_out <= {rb_sync[14:0], 1'b0};
        end else begin
            shift_out <= {shift_out[14:0], 1'b0};
        end
    end

    // first bit must appear as sync falls, before any sclk edge
    assign sdo = (bit_cnt == 5'h00) ? rb_sync[15] : shift_out[15]; // [RQ15]

    // no flip-flop sync here: sclk stands still between frames, so a synchroniser
    // would lag a frame; the word only changes after a frame ends and is settled
    // long before the next sync low, given the idle gap the host leaves between frames
    assign rb_sync = readback_word;

    // ---------------- system clock domain ----------------
    logic        tgl_sync;
    logic        tgl_seen;
    logic        word_valid;
    logic [15:0] word;
    logic [15:0] word_hold;

    scw_sync #(.W(1)) u_tgl_sync (
        .clk  (sys_clk),
        .rstn (rstn),
        .d    (word_tgl),
        .q    (tgl_sync)
    );

    // word_link is stable for a whole frame after the toggle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tgl_seen  <= 1'b0;
            word_hold <= 16'h0000;
        end else begin
            tgl_seen  <= tgl_sync;
            word_hold <= word_link;
        end
    end

    assign word_valid = tgl_sync ^ tgl_seen;
    assign word       = word_hold;

    logic [3:0]  code;
    logic [2:0]  dac_sel;
    logic        is_dac;
    logic        software_reset;
    logic [11:0] dac_reg [scw_pkg::DAC_CHANNELS];
    logic [15:0] rst_cnt;
    logic        rb_pending;

    assign is_dac   = word[scw_pkg::TYPE_BIT]; // [RQ2]
    assign code     = word[scw_pkg::CODE_HI:scw_pkg::CODE_LO]; // [RQ1]
    assign dac_sel  = word[scw_pkg::DAC_SEL_HI:scw_pkg::DAC_SEL_LO];
    assign software_reset = word_valid && !is_dac && code == scw_pkg::SOFTWARE_RESET; // [RQ1]

    // control registers; software reset returns every one to default
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            adc_sequence             <= scw_pkg::RST_DEFAULT;
            general_control          <= scw_pkg::RST_DEFAULT;
            adc_pin_select           <= scw_pkg::RST_DEFAULT;
            dac_pin_select           <= scw_pkg::RST_DEFAULT;
            pulldown_select          <= scw_pkg::RST_PULLDOWN; // [RQ4]
            readback_and_load_mode   <= scw_pkg::RST_DEFAULT;
            gpio_output_select       <= scw_pkg::RST_DEFAULT;
            gpio_output_level        <= scw_pkg::RST_DEFAULT;
            gpio_input_select        <= scw_pkg::RST_DEFAULT;
            power_down_reference     <= scw_pkg::RST_DEFAULT;
            output_drive_type_select <= scw_pkg::RST_DEFAULT;
            tristate_select          <= scw_pkg::RST_DEFAULT;
            dac_readback_select      <= scw_pkg::RST_DEFAULT;
        end else if (software_reset) begin
            adc_sequence             <= scw_pkg::RST_DEFAULT;
            general_control          <= scw_pkg::RST_DEFAULT;
            adc_pin_select           <= scw_pkg::RST_DEFAULT;
            dac_pin_select           <= scw_pkg::RST_DEFAULT;
            pulldown_select          <= scw_pkg::RST_PULLDOWN; // [RQ4]
            readback_and_load_mode   <= scw_pkg::RST_DEFAULT;
            gpio_output_select       <= scw_pkg::RST_DEFAULT;
            gpio_output_level        <= scw_pkg::RST_DEFAULT;
            gpio_input_select        <= scw_pkg::RST_DEFAULT;
            power_down_reference     <= scw_pkg::RST_DEFAULT;
            output_drive_type_select <= scw_pkg::RST_DEFAULT;
            tristate_select          <= scw_pkg::RST_DEFAULT;
            dac_readback_select      <= scw_pkg::RST_DEFAULT;
        end else if (word_valid && !is_dac) begin
            // codes 0000 and 1110 fall through untouched
            case (code)
                scw_pkg::DAC_READBACK_SELECT:  dac_readback_select      <= word[10:0]; // [RQ12]
                scw_pkg::ADC_SEQUENCE:         adc_sequence             <= word[10:0]; // [RQ5]
                scw_pkg::GENERAL_CONTROL:      general_control          <= word[10:0];
                scw_pkg::ADC_PIN_SELECT:       adc_pin_select           <= word[10:0]; // [RQ6]
                scw_pkg::DAC_PIN_SELECT:       dac_pin_select           <= word[10:0]; // [RQ6]
                scw_pkg::PULLDOWN_SELECT:      pulldown_select          <= word[10:0];
                scw_pkg::READBACK_AND_LOAD:    readback_and_load_mode   <= word[10:0]; // [RQ7]
                scw_pkg::GPIO_OUTPUT_SELECT:   gpio_output_select       <= word[10:0]; // [RQ8]
                scw_pkg::GPIO_OUTPUT_LEVEL:    gpio_output_level        <= word[10:0]; // [RQ9]
                scw_pkg::GPIO_INPUT_SELECT:    gpio_input_select        <= word[10:0]; // [RQ9]
                scw_pkg::POWER_DOWN_REFERENCE: power_down_reference     <= word[10:0]; // [RQ10]
                scw_pkg::OUTPUT_DRIVE_TYPE:    output_drive_type_select <= word[10:0]; // [RQ11]
                scw_pkg::TRISTATE_SELECT:      tristate_select          <= word[10:0]; // [RQ11]
                default: ; // [RQ19]
            endcase
        end
    end

    assign busy_on_io7 = gpio_output_select[scw_pkg::BUSY_BIT]; // [RQ8]

    // dac channel registers, also cleared by software reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < scw_pkg::DAC_CHANNELS; i++) begin
                dac_reg[i] <= 12'h000;
            end
        end else if (software_reset) begin
            for (int i = 0; i < scw_pkg::DAC_CHANNELS; i++) begin
                dac_reg[i] <= 12'h000;
            end
        end else if (word_valid && is_dac) begin
            dac_reg[dac_sel] <= word[11:0]; // [RQ3]
        end
    end

    // readback is armed by a select write and served by the next frame only
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rb_pending    <= 1'b0;
            readback_word <= 16'h0000;
        end else if (word_valid) begin
            rb_pending <= !is_dac && code == scw_pkg::DAC_READBACK_SELECT
                          && word[scw_pkg::RB_EN_HI:scw_pkg::RB_EN_LO] != 2'h0; // [RQ12]
            if (!is_dac && code == scw_pkg::DAC_READBACK_SELECT
                && word[scw_pkg::RB_EN_HI:scw_pkg::RB_EN_LO] != 2'h0) begin
                readback_word <= {1'b1, word[scw_pkg::RB_CH_HI:scw_pkg::RB_CH_LO],
                                  dac_reg[word[scw_pkg::RB_CH_HI:scw_pkg::RB_CH_LO]]}; // [RQ13]
            end else begin
                readback_word <= 16'h0000;
            end
        end
    end

    // software reset busy window, shortenable for simulation
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_cnt <= 16'h0000;
        end else if (software_reset) begin
            rst_cnt <= 16'(RESET_CYCLES);
        end else if (rst_cnt != 16'h0000) begin
            rst_cnt <= rst_cnt - 16'h0001;
        end
    end
    assign reset_busy = rst_cnt != 16'h0000;

    a_pulldown_default: assert property (@(posedge sys_clk) disable iff (!rstn)
        software_reset |=> pulldown_select == 11'h0FF && adc_sequence == 11'h000) // [RQ4]
        else $error("defaults not restored");
    a_dac_store: assert property (@(posedge sys_clk) disable iff (!rstn)
        word_valid && is_dac |=> dac_reg[$past(dac_sel)] == $past(word[11:0])) // [RQ3]
        else $error("dac payload not stored");
    a_ignore_unlisted: assert property (@(posedge sys_clk) disable iff (!rstn)
        word_valid && !is_dac && code == 4'hE |=> $stable(adc_sequence) && $stable(tristate_select)) // [RQ19]
        else $error("unlisted code changed state");
    a_seq_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        word_valid && !is_dac && code == 4'h2 |=> adc_sequence == $past(word[10:0])) // [RQ5]
        else $error("sequence not written");
    a_no_frame_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        !word_valid && !reset_busy |=> $stable(gpio_output_level)) // [RQ18]
        else $error("register changed without frame");
    a_rb_channel: assert property (@(posedge sys_clk) disable iff (!rstn)
        word_valid && !is_dac && code == 4'h1 && word[4:3] != 2'h0
        |=> readback_word[14:12] == $past(word[2:0])) // [RQ13]
        else $error("readback channel wrong");
    a_reset_window: assert property (@(posedge sys_clk) disable iff (!rstn)
        software_reset |=> reset_busy [*8]) // [RQ17]
        else $error("reset window too short");
    a_gpio_level: assert property (@(posedge sys_clk) disable iff (!rstn)
        word_valid && !is_dac && code == 4'h9 |=> gpio_output_level == $past(word[10:0])) // [RQ9]
        else $error("gpio level not written");
endmodule : scw_regbank
`default_nettype wire

// *** scw_host_model.sv ***
// serial host model that frames command words and captures the returned word
`timescale 1ns/1ps
`default_nettype none
module scw_host_model #(
    parameter int HALF = 24
) (
    output logic      sclk,
    output logic      sync_n,
    output logic      sdi,
    input  wire logic sdo
);
    logic last_bit;

    // clock idles high and stands still between frames
    initial begin
        sclk = 1'b1;
        sync_n = 1'b0;
        sdi = 1'b0;
        last_bit = 1'b1;
        // one early rising sync edge clears the link-side bit counter
        #1 sync_n = 1'b1;
    end

    // msb first, data held across each falling edge; short frames allowed on request
    task automatic frame(input logic [15:0] word, input int nbits, output logic [15:0] rd);
        rd = 16'h0000;
        sync_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi = word[15 - i];
            last_bit = word[15 - i];
            #(HALF);
            rd = {rd[14:0], sdo}; // sdo moves on rising edges and once at the first falling edge
            sclk = 1'b0;
            #(HALF) sclk = 1'b1;
        end
        #(HALF) sync_n = 1'b1;
        sdi = ~last_bit; // released line must not look like the last bit
        #(20 * HALF); // idle gap well above the minimum spacing
    endtask : frame
endmodule : scw_host_model
`default_nettype wire

// *** scw_regbank_bench.sv ***
// self-checking bench for the serial command word register bank
`timescale 1ns/1ps
`default_nettype none
module scw_regbank_bench;
    localparam int RST_CYC = 100;
    logic        sys_clk;
    logic        rstn;
    wire         sclk, sync_n, sdi, sdo, busy, rbusy;
    logic [10:0] rg [16];
    logic [10:0] exp_rg [16];
    logic [11:0] dac_m [8];
    logic [15:0] rd;
    logic [31:0] seed = 32'h7D87B33E;
    int          failures = 0;
    int          n_checks = 0;

    scw_host_model host (.sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo));
    scw_regbank #(.RESET_CYCLES(RST_CYC)) DUT (
        .sys_clk(sys_clk), .rstn(rstn), .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo),
        .adc_sequence(rg[2]), .general_control(rg[3]), .adc_pin_select(rg[4]),
        .dac_pin_select(rg[5]), .pulldown_select(rg[6]), .readback_and_load_mode(rg[7]),
        .gpio_output_select(rg[8]), .gpio_output_level(rg[9]), .gpio_input_select(rg[10]),
        .power_down_reference(rg[11]), .output_drive_type_select(rg[12]),
        .tristate_select(rg[13]), .dac_readback_select(rg[1]), .busy_on_io7(busy),
        .reset_busy(rbusy));

    // free-running system clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // readback word the host should see for a given select value
    function automatic logic [15:0] exp_rb(input logic [1:0] en, input logic [2:0] ch);
        return (en != 2'b00) ? {1'b1, ch, dac_m[ch]} : 16'h0000;
    endfunction : exp_rb

    task automatic reset_model();
        foreach (exp_rg[c]) exp_rg[c] = scw_pkg::RST_DEFAULT;
        exp_rg[6] = scw_pkg::RST_PULLDOWN;
        foreach (dac_m[c]) dac_m[c] = 12'h000;
    endtask : reset_model

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // compare every visible register and the busy pin option against the model
    task automatic check_all();
        for (int c = 1; c <= 13; c++) check($sformatf("reg%0d", c), {5'h00, rg[c]}, {5'h00, exp_rg[c]});
        check("busy_on_io7", {15'h0000, busy}, {15'h0000, exp_rg[8][8]});
    endtask : check_all

    // one full word, mirrored into the model
    task automatic send(input logic [15:0] w);
        host.frame(w, 16, rd);
        if (w[15]) dac_m[w[14:12]] = w[11:0];
        else if (w[14:11] == 4'hF) reset_model();
        else if (w[14:11] != 4'h0 && w[14:11] != 4'hE) exp_rg[w[14:11]] = w[10:0];
    endtask : send

    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // hang guard, far beyond the expected run of about 100 us
    initial begin
        #500000;
        failures++;
        print_verdict();
    end

    // main sequence
    initial begin
        logic [10:0] d;
        logic [1:0]  en;
        int          n;
        rstn = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1 rstn = 1'b1;
        reset_model();
        repeat (4) @(posedge sys_clk);
        check_all();
        for (int r = 0; r < 3; r++) begin
            for (int c = 0; c <= 14; c++) begin
                d = 11'(rnd());
                if (c == 1) d = d & 11'h01F; // reserved bits sent as zero
                if (r == 2) d = (c == 1) ? 11'h01F : 11'h7FF;
                send({1'b0, 4'(c), d});
                check_all();
            end
        end
        for (int ch = 0; ch < 8; ch++) send({1'b1, 3'(ch), 12'(rnd())});
        for (int ch = 7; ch >= 0; ch--) begin
            en = 2'(ch);
            send({1'b0, 4'h1, 6'h00, en, 3'(ch)});
            send(16'h0000);
            check("readback", rd, exp_rb(en, 3'(ch)));
        end
        host.frame({1'b0, 4'h2, 11'h555}, 10, rd);
        host.frame({1'b1, 3'h4, 12'hABC}, 15, rd);
        check_all();
        send({1'b0, 4'h1, 6'h00, 2'b01, 3'h4});
        send(16'h0000);
        check("short dac", rd, exp_rb(2'b01, 3'h4));
        send({1'b0, 4'hF, 11'h000});
        check("reset_busy", {15'h0000, rbusy}, 16'h0001);
        n = 0;
        while (rbusy !== 1'b0 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        check("busy wait", {15'h0000, rbusy}, 16'h0000);
        check_all();
        send({1'b0, 4'h1, 6'h00, 2'b11, 3'h5});
        send(16'h0000);
        check("readback after reset", rd, exp_rb(2'b11, 3'h5));
        print_verdict();
    end
endmodule : scw_regbank_bench
`default_nettype wire
